/* File: rtl/dac_serial_config_port.sv */
// serial configuration port: link shifter on sclk, register file on clk
`timescale 1ns/10ps
`include "dac_serial_map.svh"

module dac_serial_config_port #(
  parameter int TIMEOUT_CYCLES = `TIMEOUT_CYCLES,
  // identification bits, arbitrary value
  parameter logic [2:0] ID_BITS = 3'h5
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout,
  output logic doutEn,
  input wire logic resetPowerdownPin_n,
  output logic [`REG_COUNT-1:0][7:0] configRegs,
  output logic portHeld
);

  // ---------------- link domain (sclk) ----------------
  dac_serial_pkg::link_state_t state;
  dac_serial_pkg::link_state_t next_state;
  logic [2:0] bitCount;
  logic [2:0] next_bitCount;
  logic [6:0] shiftIn;
  logic [6:0] next_shiftIn;
  dac_serial_pkg::reg_addr_t ptr;
  dac_serial_pkg::reg_addr_t next_ptr;
  logic [3:0] remaining;
  logic [3:0] next_remaining;
  dac_serial_pkg::reg_addr_t wrAddr;
  dac_serial_pkg::reg_addr_t next_wrAddr;
  dac_serial_pkg::reg_byte_t wrData;
  dac_serial_pkg::reg_byte_t next_wrData;
  logic wrToggle;
  logic next_wrToggle;
  logic rstToggle;
  logic next_rstToggle;
  dac_serial_pkg::reg_byte_t outByte;
  dac_serial_pkg::reg_byte_t next_outByte;
  logic next_dout;

  logic holdLink;
  logic linkReset_n;
  logic byteDone;
  dac_serial_pkg::reg_byte_t rxByte;
  dac_serial_pkg::reg_addr_t ptrInc;
  dac_serial_pkg::reg_byte_t readValue;

  // chip select high or a clk-side hold keeps the link in reset
  assign linkReset_n = !cs_n && !holdLink;
  // tied-low select leaves the output driven except while holdLink is set
  // no tri-state inside the block: the enable goes to the pin cell
  assign doutEn = !cs_n && !holdLink;

  assign byteDone = (bitCount == `BIT_LAST);
  assign rxByte = {shiftIn, din};
  // pointer stops at the top instead of wrapping
  assign ptrInc = (ptr == `PTR_MAX) ? ptr : ptr + 4'h1;

  // register contents are quasi-static during a read: nothing writes them
  // while the link is busy shifting out, so sampling across domains is safe
  always_comb begin
    readValue = 8'h00;
    if (ptr <= `REG_LAST_ADDR) begin
      readValue = configRegs[ptr];
    end
    if (ptr == `ADDR_GAIN_MODE) begin
      readValue[`ID_MSB:`ID_LSB] = ID_BITS;
    end
  end

  always_comb begin
    next_state = state;
    next_bitCount = bitCount + 3'h1;
    next_shiftIn = rxByte[6:0];
    next_ptr = ptr;
    next_remaining = remaining;
    next_wrAddr = wrAddr;
    next_wrData = wrData;
    next_wrToggle = wrToggle;
    next_rstToggle = rstToggle;
    if (byteDone) begin
      unique case (state)
        dac_serial_pkg::LINK_OPCODE: begin
          if (rxByte[7:4] == `CMD_READ_NIB) begin
            next_ptr = rxByte[3:0];
            next_state = dac_serial_pkg::LINK_COUNT_RD;
          end else if (rxByte[7:4] == `CMD_WRITE_NIB) begin
            next_ptr = rxByte[3:0];
            next_state = dac_serial_pkg::LINK_COUNT_WR;
          end else if (rxByte[7:1] == `CMD_RESET_HI7) begin
            next_rstToggle = !rstToggle;
          end
          // any other opcode byte falls through untouched
        end
        dac_serial_pkg::LINK_COUNT_RD: begin
          // upper nibble of the count byte is don't-care
          next_remaining = rxByte[3:0];
          next_state = dac_serial_pkg::LINK_READING;
        end
        dac_serial_pkg::LINK_COUNT_WR: begin
          next_remaining = rxByte[3:0];
          next_state = dac_serial_pkg::LINK_WRITING;
        end
        dac_serial_pkg::LINK_WRITING: begin
          next_wrAddr = ptr;
          next_wrData = rxByte;
          next_wrToggle = !wrToggle;
          next_ptr = ptrInc;
          if (remaining == 4'h0) begin
            next_state = dac_serial_pkg::LINK_OPCODE;
          end else begin
            next_remaining = remaining - 4'h1;
          end
        end
        dac_serial_pkg::LINK_READING: begin
          // din is ignored while data flows outward
          next_ptr = ptrInc;
          if (remaining == 4'h0) begin
            next_state = dac_serial_pkg::LINK_OPCODE;
          end else begin
            next_remaining = remaining - 4'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sclk or negedge linkReset_n) begin
    if (!linkReset_n) begin
      state <= dac_serial_pkg::LINK_OPCODE;
      bitCount <= `BIT_FIRST;
      shiftIn <= 7'h00;
      ptr <= 4'h0;
      remaining <= 4'h0;
    end else begin
      state <= next_state;
      bitCount <= next_bitCount;
      shiftIn <= next_shiftIn;
      ptr <= next_ptr;
      remaining <= next_remaining;
    end
  end

  // toggles survive link resets so no event is lost or doubled
  // the write word stays out of the select reset too: a host may raise
  // select right after the last bit, before the clk side has taken the word
  always_ff @(posedge sclk or negedge reset_n) begin
    if (!reset_n) begin
      wrToggle <= 1'b0;
      rstToggle <= 1'b0;
      wrAddr <= 4'h0;
      wrData <= 8'h00;
    end else begin
      wrToggle <= next_wrToggle;
      rstToggle <= next_rstToggle;
      wrAddr <= next_wrAddr;
      wrData <= next_wrData;
    end
  end

  always_comb begin
    next_outByte = outByte;
    next_dout = dout;
    if (state == dac_serial_pkg::LINK_READING) begin
      if (bitCount == `BIT_FIRST) begin
        // first read byte loads on the sixteenth falling edge
        next_outByte = readValue;
        next_dout = readValue[7];
      end else begin
        next_dout = outByte[`BIT_LAST - bitCount];
      end
    end
  end

  always_ff @(negedge sclk or negedge linkReset_n) begin
    if (!linkReset_n) begin
      outByte <= 8'h00;
      dout <= 1'b0;
    end else begin
      outByte <= next_outByte;
      dout <= next_dout;
    end
  end

  // ---------------- master clock domain (clk) ----------------
  logic sclkMeta;
  logic sclkSync;
  logic pinMeta;
  logic pinSync;
  logic wrMeta;
  logic wrSync;
  logic wrSeen;
  logic rstMeta;
  logic rstSync;
  logic rstSeen;
  logic timeoutPulse;
  logic next_holdLink;
  logic [`REG_COUNT-1:0][7:0] next_configRegs;
  logic wrEvent;
  logic rstEvent;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sclkMeta <= 1'b0;
      sclkSync <= 1'b0;
      pinMeta <= 1'b0;
      pinSync <= 1'b0;
      wrMeta <= 1'b0;
      wrSync <= 1'b0;
      wrSeen <= 1'b0;
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
      rstSeen <= 1'b0;
    end else begin
      // two stages on sclk, the pin and both toggles as they cross into clk
      sclkMeta <= sclk;
      sclkSync <= sclkMeta;
      pinMeta <= resetPowerdownPin_n;
      pinSync <= pinMeta;
      wrMeta <= wrToggle;
      wrSync <= wrMeta;
      wrSeen <= wrSync;
      rstMeta <= rstToggle;
      rstSync <= rstMeta;
      rstSeen <= rstSync;
    end
  end

  assign wrEvent = (wrSync != wrSeen);
  assign rstEvent = (rstSync != rstSeen);

  sclk_timeout #(
    .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
  ) watchdog (
    .clk(clk),
    .reset_n(reset_n),
    .sclkLevel(sclkSync),
    .timeoutPulse(timeoutPulse)
  );

  assign next_holdLink = !pinSync || timeoutPulse;
  assign portHeld = holdLink;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      // link stays held until the pin sync has seen the pin high
      holdLink <= 1'b1;
    end else begin
      holdLink <= next_holdLink;
    end
  end

  // write data is stable for a whole byte time after the toggle moves
  genvar idx;
  generate
    for (idx = 0; idx < `REG_COUNT; idx++) begin : gen_reg
      localparam logic [3:0] ADDR = 4'(idx);
      localparam logic [7:0] DEFAULT = (ADDR == `ADDR_GAIN_MODE) ? `DEF_GAIN_MODE :
                                       (ADDR == `ADDR_FREQ_DIV) ? `DEF_FREQ_DIV : `DEF_OTHER;
      localparam logic [7:0] MASK = (ADDR == `ADDR_GAIN_MODE) ? `MASK_GAIN_MODE :
                                    (ADDR == `ADDR_PULSE_A || ADDR == `ADDR_PULSE_B) ? `MASK_PULSE : `MASK_FULL;
      always_comb begin
        next_configRegs[idx] = configRegs[idx];
        if (!pinSync || rstEvent) begin
          next_configRegs[idx] = DEFAULT;
        end else if (wrEvent && wrAddr == ADDR) begin
          next_configRegs[idx] = wrData & MASK;
        end
      end
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          configRegs[idx] <= DEFAULT;
        end else begin
          configRegs[idx] <= next_configRegs[idx];
        end
      end
    end
  endgenerate

endmodule : dac_serial_config_port

/* File: rtl/dac_serial_map.svh */
// constants of the serial configuration port: offsets, defaults, masks, opcodes, counts
`ifndef DAC_SERIAL_MAP_SVH
`define DAC_SERIAL_MAP_SVH

`define REG_COUNT 9
`define REG_LAST_ADDR 4'h8
`define ADDR_GAIN_MODE 4'h0
`define ADDR_SINE_GAIN 4'h1
`define ADDR_SWITCH_MODE 4'h2
`define ADDR_FREQ_DIV 4'h3
`define ADDR_DC_GAIN0 4'h4
`define ADDR_DC_GAIN1 4'h5
`define ADDR_DC_GAIN2 4'h6
`define ADDR_PULSE_A 4'h7
`define ADDR_PULSE_B 4'h8

`define DEF_GAIN_MODE 8'h18
`define DEF_FREQ_DIV 8'h07
`define DEF_OTHER 8'h00

`define MASK_GAIN_MODE 8'h1F
`define MASK_PULSE 8'h1F
`define MASK_FULL 8'hFF
`define ID_MSB 7
`define ID_LSB 5

`define CMD_READ_NIB 4'h2
`define CMD_WRITE_NIB 4'h4
`define CMD_RESET_HI7 7'h03

`define BIT_LAST 3'h7
`define BIT_FIRST 3'h0
`define PTR_MAX 4'hF

`define TIMEOUT_CYCLES 262144
`define TIMEOUT_HOLD 3'h4

`endif

/* File: rtl/dac_serial_pkg.sv */
// types shared by the serial configuration port
package dac_serial_pkg;

  typedef enum logic [4:0] {
    LINK_OPCODE   = 5'h01,
    LINK_COUNT_RD = 5'h02,
    LINK_COUNT_WR = 5'h04,
    LINK_WRITING  = 5'h08,
    LINK_READING  = 5'h10
  } link_state_t;

  typedef logic [7:0] reg_byte_t;
  typedef logic [3:0] reg_addr_t;

endpackage : dac_serial_pkg

/* File: rtl/sclk_timeout.sv */
// idle-low serial clock watchdog counted in master clock cycles
`timescale 1ns/10ps
`include "dac_serial_map.svh"

module sclk_timeout #(
  parameter int TIMEOUT_CYCLES = `TIMEOUT_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sclkLevel,
  output logic timeoutPulse
);

  logic [18:0] lowCount;
  logic [18:0] next_lowCount;
  logic [2:0] holdCount;
  logic [2:0] next_holdCount;
  logic next_timeoutPulse;

  always_comb begin
    next_lowCount = lowCount + 19'h00001;
    // hold counts down on its own so the pulse always ends
    next_holdCount = (holdCount != 3'h0) ? holdCount - 3'h1 : 3'h0;
    if (sclkLevel) begin
      // a high idle never counts, so it never resets the port
      next_lowCount = 19'h00000;
    end else if (lowCount == 19'(TIMEOUT_CYCLES - 1)) begin
      // fires again on every full interval while sclk stays low
      next_lowCount = 19'h00000;
      next_holdCount = `TIMEOUT_HOLD;
    end
    // stretched so the link reset outlives any clock skew
    next_timeoutPulse = (next_holdCount != 3'h0);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lowCount <= 19'h00000;
      holdCount <= 3'h0;
      timeoutPulse <= 1'b0;
    end else begin
      lowCount <= next_lowCount;
      holdCount <= next_holdCount;
      timeoutPulse <= next_timeoutPulse;
    end
  end

endmodule : sclk_timeout

/* File: bench/dac_serial_config_port_checker.sv */
// pin-level assertions for the serial configuration port
`timescale 1ns/10ps
`include "dac_serial_map.svh"
module dac_serial_config_port_checker #(
  parameter int TIMEOUT_CYCLES = 64
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic dout,
  input wire logic doutEn,
  input wire logic resetPowerdownPin_n,
  input wire logic [`REG_COUNT-1:0][7:0] configRegs,
  input wire logic portHeld
);
  int lowCnt;
  int highCnt;
  // raw sclk run lengths; the design sees sclk a few cycles later
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lowCnt <= 0;
      highCnt <= 0;
    end else begin
      lowCnt <= sclk ? 0 : lowCnt + 1;
      highCnt <= (sclk && resetPowerdownPin_n) ? highCnt + 1 : 0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  AST_EN_DESELECT: assert property (cs_n |-> !doutEn)
    else $error("dout driven while deselected");
  AST_EN_SELECT: assert property ((!cs_n && !portHeld) |-> doutEn)
    else $error("dout floats while selected");
  AST_DOUT_FALL: assert property ((!cs_n && $past(!cs_n) && $changed(dout)) |-> !sclk)
    else $error("dout moved outside a falling edge");
  AST_TIMEOUT: assert property ((lowCnt == TIMEOUT_CYCLES + 4 && resetPowerdownPin_n) |-> ##[0:10] portHeld)
    else $error("no link reset after idle-low timeout");
  AST_HIGH_IDLE: assert property (highCnt >= 12 |-> !portHeld)
    else $error("link reset while sclk idles high");
  AST_PIN_HELD: assert property (!resetPowerdownPin_n [*4] |-> portHeld && !doutEn)
    else $error("link not held by reset pin");
  AST_PIN_DEFAULT: assert property (!resetPowerdownPin_n [*5] |-> configRegs[0] == `DEF_GAIN_MODE
    && configRegs[3] == `DEF_FREQ_DIV && configRegs[1] == `DEF_OTHER && configRegs[8] == `DEF_OTHER)
    else $error("registers not at defaults under reset pin");
  AST_CS_IGNORE: assert property ((cs_n && resetPowerdownPin_n) [*8] |-> $stable(configRegs))
    else $error("registers changed while deselected");
  AST_RSV_BITS: assert property (configRegs[0][7:5] == 3'h0 && configRegs[7][7:5] == 3'h0
    && configRegs[8][7:5] == 3'h0)
    else $error("reserved register bits set");
endmodule : dac_serial_config_port_checker

bind dac_serial_config_port dac_serial_config_port_checker #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES))
  i_dac_serial_config_port_checker (.clk(clk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n), .din(din),
  .dout(dout), .doutEn(doutEn), .resetPowerdownPin_n(resetPowerdownPin_n), .configRegs(configRegs),
  .portHeld(portHeld));

/* File: bench/spi_host_model.sv */
// serial master model driving the link pins
`timescale 1ns/10ps
module spi_host_model (
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire logic dout,
  input wire logic doutEn
);
  logic idleHigh = 1'b0;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b1;
  end
  task automatic open_frame();
    // restart the idle timer while deselected so no reset lands on the command
    if (!idleHigh) begin
      sclk = 1'b1;
      #6 sclk = 1'b0;
    end
    #40 cs_n = 1'b0;
  endtask : open_frame
  task automatic close_frame();
    #6 cs_n = 1'b1;
    din = ~din;
  endtask : close_frame
  task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    for (int i = 7; i > 7 - nbits; i--) begin
      sclk = 1'b0;
      din = tx[i];
      #6 sclk = 1'b1;
      // a floating pin reads back inverted, so a lost enable shows as a mismatch
      rx[i] = doutEn ? dout : !dout;
      #6;
    end
    sclk = idleHigh;
  endtask : xfer
endmodule : spi_host_model

/* File: bench/dac_serial_config_port_tb.sv */
// self-checking bench with a register model
`timescale 1ns/10ps
`include "dac_serial_map.svh"
module dac_serial_config_port_tb;
  localparam int TO = 64;
  localparam logic [2:0] IDB = 3'h5; // arbitrary identification value
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic resetPowerdownPin_n = 1'b1;
  logic sclk, cs_n, din, dout, doutEn, portHeld;
  logic [`REG_COUNT-1:0][7:0] configRegs;
  int n_fail = 0;
  int cmp_count = 0;
  int mdl[9];
  logic [7:0] rx;
  always #2 clk = ~clk;
  dac_serial_config_port #(.TIMEOUT_CYCLES(TO), .ID_BITS(IDB)) i_dac_serial_config_port (.clk(clk),
    .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .doutEn(doutEn),
    .resetPowerdownPin_n(resetPowerdownPin_n), .configRegs(configRegs), .portHeld(portHeld));
  spi_host_model i_spi_host_model (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .doutEn(doutEn));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic defaults();
    foreach (mdl[i]) mdl[i] = 0;
    mdl[0] = 8'h18;
    mdl[3] = 8'h07;
  endtask : defaults
  task automatic cmp_regs();
    for (int i = 0; i < 9; i++) check(configRegs[i], 8'(mdl[i]));
  endtask : cmp_regs
  task automatic send(input int b, input int nb = 8);
    i_spi_host_model.xfer(8'(b), nb, rx);
  endtask : send
  task automatic open();
    @(posedge clk);
    #1 i_spi_host_model.open_frame();
  endtask : open
  task automatic finish_cmd();
    i_spi_host_model.close_frame();
    repeat (12) @(posedge clk);
  endtask : finish_cmd
  // pre: -1 plain, -2 frame already open, else a byte sent ahead of the opcode
  task automatic wr(input int a, input int n, input int pre = -1);
    int v;
    if (pre != -2) open();
    if (pre >= 0) send(pre);
    send(8'h40 | a);
    send(n - 1);
    for (int i = 0; i < n; i++) begin
      v = $urandom & 8'hFF;
      send(v);
      // upper bits of the gain-mode and pulse registers do not exist
      if (a + i <= 8) mdl[a + i] = (a + i == 0 || a + i > 6) ? v & 8'h1F : v;
    end
    finish_cmd();
    cmp_regs();
  endtask : wr
  task automatic rd(input int a, input int n);
    int x;
    open();
    send(8'h20 | a);
    send(n - 1);
    for (int i = 0; i < n; i++) begin
      x = a + i;
      send($urandom);
      check(rx, x > 8 ? 8'h00 : x == 0 ? {IDB, 5'(mdl[0])} : 8'(mdl[x]));
    end
    finish_cmd();
  endtask : rd
  task automatic tally_and_finish();
    $display("compares=%0d mismatches=%0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  initial begin
    #200000;
    n_fail++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'h7053E3F5));
    defaults();
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge clk);
    cmp_regs();
    rd(0, 9);
    wr(0, 9);
    rd(0, 9);
    wr(7, 4);
    rd(7, 4);
    wr(2, 2, 8'h30);
    wr(5, 1, 8'hFF);
    for (int c = 6; c < 8; c++) begin
      wr(1, 3);
      open();
      send(c);
      finish_cmd();
      defaults();
      cmp_regs();
    end
    open();
    send(8'h4F, 4);
    finish_cmd();
    wr(2, 1);
    open();
    send(8'h41, 3);
    repeat (TO + 20) @(posedge clk);
    wr(3, 1, -2);
    i_spi_host_model.idleHigh = 1'b1;
    send(0, 0);
    repeat (3 * TO) @(posedge clk);
    wr(4, 2);
    i_spi_host_model.idleHigh = 1'b0;
    send(0, 0);
    rd(4, 2);
    wr(5, 3);
    @(posedge clk);
    resetPowerdownPin_n <= 1'b0;
    repeat (8) @(posedge clk);
    defaults();
    cmp_regs();
    resetPowerdownPin_n <= 1'b1;
    repeat (8) @(posedge clk);
    rd(0, 9);
    tally_and_finish();
  end
endmodule : dac_serial_config_port_tb
